// file: include/spms_defs.svh
`ifndef SPMS_DEFS_SVH
`define SPMS_DEFS_SVH

// Core clock period and master serial half period, both in ns
`define SPMS_CLK_PERIOD_NS   25
`define SPMS_SCK_HALF_NS     100
// Least time, so round up to whole core cycles
`define SPMS_SCK_HALF_CYC    ((`SPMS_SCK_HALF_NS + `SPMS_CLK_PERIOD_NS - 1) / `SPMS_CLK_PERIOD_NS)

// Serial clock edges in one byte transfer
`define SPMS_EDGES_PER_BYTE  5'h10

// Pin index inside the synchroniser vectors
`define SPMS_PIN_SCLK        0
`define SPMS_PIN_MOSI        1
`define SPMS_PIN_MISO        2
`define SPMS_PIN_SEL         3

// Reset values
`define SPMS_PIN_LEVEL_RST   4'hf
`define SPMS_BYTE_RST        8'h00
`define SPMS_TX_EMPTY_RST    1'b1

`endif

// file: include/spms_pkg.sv
package spms_pkg;

  // Gray coded along idle, lead, run, trail
  typedef enum logic [1:0] {
    SPMS_IDLE  = 2'b00,
    SPMS_LEAD  = 2'b01,
    SPMS_RUN   = 2'b11,
    SPMS_TRAIL = 2'b10
  } spms_state_t;

endpackage

// file: logic/spms_core.sv
`timescale 1ns/10ps
`include "spms_defs.svh"
module spms_core
  import spms_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       dataWrite,
  input  wire logic [7:0] dataWriteValue,
  input  wire logic       dataRead,
  input  wire logic       statusRead,
  input  wire logic       ctrlWrite,
  input  wire logic       ctrlEnable,
  input  wire logic       ctrlMasterSelect,
  input  wire logic       ctrlClockPolaritySelect,
  input  wire logic       ctrlClockPhaseSelect,
  input  wire logic       ctrlLowBitFirstEnable,
  input  wire logic       ctrlRxFaultIrqEnable,
  input  wire logic       ctrlTxEmptyIrqEnable,
  input  wire logic       ctrlSelectOutputEnable,
  input  wire logic       ctrlFaultDetectEnable,
  input  wire logic       ctrlBidirMode,
  input  wire logic       sclkIn,
  input  wire logic       mosiIn,
  input  wire logic       misoIn,
  input  wire logic       selectIn_n,
  output logic            sclkOut,
  output logic            sclkOe,
  output logic            mosiOut,
  output logic            mosiOe,
  output logic            misoOut,
  output logic            misoOe,
  output logic            selectOut_n,
  output logic            selectOe,
  output logic [7:0]      serialDataRegister,
  output logic            txBufferEmptyFlag,
  output logic            rxBufferFullFlag,
  output logic            modeFaultFlag,
  output logic            masterSelect,
  output logic            irqRequest,
  output logic            transferActive
);

  localparam logic [7:0] HALF_LAST = 8'(`SPMS_SCK_HALF_CYC - 1);

  // Pin synchronisers: three stages, a change counts once stages two and three agree
  logic [3:0] pinSync1;
  logic [3:0] pinSync2;
  logic [3:0] pinSync3;
  logic [3:0] pinLevel;
  logic [3:0] pinAgreed;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinSync1 <= `SPMS_PIN_LEVEL_RST;
      pinSync2 <= `SPMS_PIN_LEVEL_RST;
      pinSync3 <= `SPMS_PIN_LEVEL_RST;
      pinLevel <= `SPMS_PIN_LEVEL_RST;
    end else begin
      pinSync1 <= {selectIn_n, misoIn, mosiIn, sclkIn};
      pinSync2 <= pinSync1;
      pinSync3 <= pinSync2;
      pinLevel <= (pinSync2 & pinSync3) | (pinLevel & (pinSync2 ^ pinSync3));
    end
  end

  // Configuration, captured on each write of the first control register
  logic enable;
  logic clockPolaritySelect;
  logic clockPhaseSelect;
  logic lowBitFirstEnable;
  logic rxFaultIrqEnable;
  logic txEmptyIrqEnable;
  logic selectOutputEnable;
  logic faultDetectEnable;
  logic bidirMode;

  // Engine state
  spms_state_t state;
  spms_state_t next_state;
  logic [7:0]  halfCnt;
  logic [7:0]  next_halfCnt;
  logic [4:0]  edgeCnt;
  logic [4:0]  next_edgeCnt;
  logic [7:0]  shifter;
  logic [7:0]  next_shifter;
  logic [7:0]  txBuffer;
  logic [7:0]  next_txBuffer;
  logic        sampleBit;
  logic        next_sampleBit;
  logic        sclkPhase;
  logic        next_sclkPhase;
  logic        txArmed;
  logic        next_txArmed;
  logic        rxArmed;
  logic        next_rxArmed;
  logic        faultArmed;
  logic        next_faultArmed;
  logic [7:0]  next_serialDataRegister;
  logic        next_txBufferEmptyFlag;
  logic        next_rxBufferFullFlag;
  logic        next_modeFaultFlag;
  logic        next_masterSelect;
  logic        next_sclkOut;
  logic        next_sclkOe;
  logic        next_mosiOut;
  logic        next_mosiOe;
  logic        next_misoOut;
  logic        next_misoOe;
  logic        next_selectOut_n;
  logic        next_selectOe;
  logic        next_irqRequest;
  logic        next_transferActive;

  logic       selected;
  logic       sclkEdge;
  logic       faultInput;
  logic       fault;
  logic       edgeNow;
  logic [4:0] edgeIdx;
  logic       inBit;
  logic       isSample;
  logic       isShift;
  logic       complete;

  always_comb begin
    next_state              = state;
    next_halfCnt            = halfCnt;
    next_edgeCnt            = edgeCnt;
    next_shifter            = shifter;
    next_txBuffer           = txBuffer;
    next_sampleBit          = sampleBit;
    next_sclkPhase          = sclkPhase;
    next_txArmed            = txArmed;
    next_rxArmed            = rxArmed;
    next_faultArmed         = faultArmed;
    next_serialDataRegister = serialDataRegister;
    next_txBufferEmptyFlag  = txBufferEmptyFlag;
    next_rxBufferFullFlag   = rxBufferFullFlag;
    next_modeFaultFlag      = modeFaultFlag;
    next_masterSelect       = ctrlWrite ? ctrlMasterSelect : masterSelect;

    selected   = !pinLevel[`SPMS_PIN_SEL];
    sclkEdge   = (pinSync2[`SPMS_PIN_SCLK] == pinSync3[`SPMS_PIN_SCLK]) &&
                 (pinSync3[`SPMS_PIN_SCLK] != pinLevel[`SPMS_PIN_SCLK]);
    faultInput = masterSelect && faultDetectEnable && !selectOutputEnable;
    fault      = enable && faultInput && selected;
    // Take a data pin as soon as stages two and three agree: the registered level is one
    // cycle too late for a remote bit launched on our own edge four cycles earlier
    pinAgreed  = (pinSync2 & pinSync3) | (pinLevel & (pinSync2 ^ pinSync3));
    inBit      = masterSelect ? pinAgreed[`SPMS_PIN_MISO] : pinAgreed[`SPMS_PIN_MOSI];
    edgeNow    = 1'b0;
    complete   = 1'b0;

    // Status read arms the clears; armed state is dropped once used
    if (statusRead) begin
      next_txArmed    = txBufferEmptyFlag;
      next_rxArmed    = rxBufferFullFlag;
      next_faultArmed = modeFaultFlag;
    end
    if (dataWrite && txArmed && txBufferEmptyFlag) begin
      next_txBuffer          = dataWriteValue;
      next_txBufferEmptyFlag = 1'b0;
      next_txArmed           = 1'b0;
    end
    if (dataRead && rxArmed && rxBufferFullFlag) begin
      next_rxBufferFullFlag = 1'b0;
      next_rxArmed          = 1'b0;
    end
    if (ctrlWrite && faultArmed && modeFaultFlag) begin
      next_modeFaultFlag = 1'b0;
      next_faultArmed    = 1'b0;
    end

    // Master timeline: lead half, sixteen edges a half apart, trail half
    if (masterSelect && enable) begin
      case (state)
        SPMS_IDLE: begin
          if (!txBufferEmptyFlag) begin
            next_shifter           = txBuffer;
            next_txBufferEmptyFlag = 1'b1;
            next_halfCnt           = 8'h00;
            next_edgeCnt           = 5'h00;
            next_state             = SPMS_LEAD;
          end
        end
        SPMS_LEAD, SPMS_RUN: begin
          if (halfCnt == HALF_LAST) begin
            next_halfCnt = 8'h00;
            if (state == SPMS_LEAD) begin
              next_state = SPMS_RUN;
            end
            edgeNow        = (state == SPMS_RUN) || 1'b1;
            next_sclkPhase = !sclkPhase;
          end else begin
            next_halfCnt = halfCnt + 8'h01;
          end
        end
        SPMS_TRAIL: begin
          // Select rises here, so the next byte waits one idle cycle
          if (halfCnt == HALF_LAST) begin
            next_halfCnt = 8'h00;
            next_state   = SPMS_IDLE;
          end else begin
            next_halfCnt = halfCnt + 8'h01;
          end
        end
        default: begin
          next_state = SPMS_IDLE;
        end
      endcase
    end else begin
      next_state     = SPMS_IDLE;
      next_halfCnt   = 8'h00;
      next_sclkPhase = 1'b0;
      if (!selected || !enable) begin
        next_edgeCnt = 5'h00;
      end else begin
        edgeNow = sclkEdge;
      end
      // Slave preloads while between bytes so the first bit is ready on select
      if (enable && edgeCnt == 5'h00 && !edgeNow && !txBufferEmptyFlag) begin
        next_shifter           = txBuffer;
        next_txBufferEmptyFlag = 1'b1;
      end
    end

    // Edge action by index and phase
    edgeIdx  = edgeCnt + 5'h01;
    isSample = clockPhaseSelect ? !edgeIdx[0] : edgeIdx[0];
    isShift  = clockPhaseSelect ? (edgeIdx[0] && edgeIdx != 5'h01) : !edgeIdx[0];
    if (edgeNow) begin
      if (masterSelect && state == SPMS_LEAD) begin
        // Lead half ends on the first edge, counted below
      end
      next_edgeCnt = edgeIdx;
      if (isSample) begin
        next_sampleBit = inBit;
      end
      if (isShift || (clockPhaseSelect && edgeIdx == `SPMS_EDGES_PER_BYTE)) begin
        if (lowBitFirstEnable) begin
          next_shifter = {(isShift ? sampleBit : inBit), shifter[7:1]};
        end else begin
          next_shifter = {shifter[6:0], (isShift ? sampleBit : inBit)};
        end
      end
      if (edgeIdx == `SPMS_EDGES_PER_BYTE) begin
        complete     = 1'b1;
        next_edgeCnt = 5'h00;
        if (masterSelect) begin
          next_state = SPMS_TRAIL;
        end
      end
    end

    if (complete) begin
      // Set beats a clear arriving in the same cycle; a full buffer drops the byte
      if (!rxBufferFullFlag || !next_rxBufferFullFlag) begin
        next_serialDataRegister = next_shifter;
      end
      next_rxBufferFullFlag = 1'b1;
    end

    if (fault) begin
      next_modeFaultFlag = 1'b1;
      next_masterSelect  = 1'b0;
      next_state         = SPMS_IDLE;
      next_edgeCnt       = 5'h00;
      next_halfCnt       = 8'h00;
      next_sclkPhase     = 1'b0;
    end

    next_sclkOut        = clockPolaritySelect ^ next_sclkPhase;
    next_sclkOe         = enable && next_masterSelect && !fault;
    next_mosiOe         = enable && next_masterSelect && !fault;
    next_misoOe         = enable && !next_masterSelect && selected &&
                          !(next_modeFaultFlag && !bidirMode);
    // Data out never moves on a sample edge, so the far side never races the clock
    if (edgeNow && isSample) begin
      next_mosiOut = mosiOut;
    end else begin
      next_mosiOut = lowBitFirstEnable ? next_shifter[0] : next_shifter[7];
    end
    next_misoOut        = next_mosiOut;
    next_selectOe       = enable && next_masterSelect && faultDetectEnable && selectOutputEnable;
    next_selectOut_n    = (next_state == SPMS_IDLE);
    next_transferActive = (next_state != SPMS_IDLE) || (next_edgeCnt != 5'h00);
    next_irqRequest     = (rxFaultIrqEnable && (next_rxBufferFullFlag || next_modeFaultFlag)) ||
                          (txEmptyIrqEnable && next_txBufferEmptyFlag);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable              <= 1'b0;
      clockPolaritySelect <= 1'b0;
      clockPhaseSelect    <= 1'b0;
      lowBitFirstEnable   <= 1'b0;
      rxFaultIrqEnable    <= 1'b0;
      txEmptyIrqEnable    <= 1'b0;
      selectOutputEnable  <= 1'b0;
      faultDetectEnable   <= 1'b0;
      bidirMode           <= 1'b0;
      state               <= SPMS_IDLE;
      halfCnt             <= 8'h00;
      edgeCnt             <= 5'h00;
      shifter             <= `SPMS_BYTE_RST;
      txBuffer            <= `SPMS_BYTE_RST;
      sampleBit           <= 1'b0;
      sclkPhase           <= 1'b0;
      txArmed             <= 1'b0;
      rxArmed             <= 1'b0;
      faultArmed          <= 1'b0;
      serialDataRegister  <= `SPMS_BYTE_RST;
      txBufferEmptyFlag   <= `SPMS_TX_EMPTY_RST;
      rxBufferFullFlag    <= 1'b0;
      modeFaultFlag       <= 1'b0;
      masterSelect        <= 1'b0;
      sclkOut             <= 1'b0;
      sclkOe              <= 1'b0;
      mosiOut             <= 1'b0;
      mosiOe              <= 1'b0;
      misoOut             <= 1'b0;
      misoOe              <= 1'b0;
      selectOut_n         <= 1'b1;
      selectOe            <= 1'b0;
      irqRequest          <= 1'b0;
      transferActive      <= 1'b0;
    end else begin
      if (ctrlWrite) begin
        enable              <= ctrlEnable;
        clockPolaritySelect <= ctrlClockPolaritySelect;
        clockPhaseSelect    <= ctrlClockPhaseSelect;
        lowBitFirstEnable   <= ctrlLowBitFirstEnable;
        rxFaultIrqEnable    <= ctrlRxFaultIrqEnable;
        txEmptyIrqEnable    <= ctrlTxEmptyIrqEnable;
        selectOutputEnable  <= ctrlSelectOutputEnable;
        faultDetectEnable   <= ctrlFaultDetectEnable;
        bidirMode           <= ctrlBidirMode;
      end
      state              <= next_state;
      halfCnt            <= next_halfCnt;
      edgeCnt            <= next_edgeCnt;
      shifter            <= next_shifter;
      txBuffer           <= next_txBuffer;
      sampleBit          <= next_sampleBit;
      sclkPhase          <= next_sclkPhase;
      txArmed            <= next_txArmed;
      rxArmed            <= next_rxArmed;
      faultArmed         <= next_faultArmed;
      serialDataRegister <= next_serialDataRegister;
      txBufferEmptyFlag  <= next_txBufferEmptyFlag;
      rxBufferFullFlag   <= next_rxBufferFullFlag;
      modeFaultFlag      <= next_modeFaultFlag;
      masterSelect       <= next_masterSelect;
      sclkOut            <= next_sclkOut;
      sclkOe             <= next_sclkOe;
      mosiOut            <= next_mosiOut;
      mosiOe             <= next_mosiOe;
      misoOut            <= next_misoOut;
      misoOe             <= next_misoOe;
      selectOut_n        <= next_selectOut_n;
      selectOe           <= next_selectOe;
      irqRequest         <= next_irqRequest;
      transferActive     <= next_transferActive;
    end
  end

endmodule

// file: testbench/spms_core_chk.sv
`timescale 1ns/10ps
module spms_core_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic dataWrite,
  input wire logic dataRead,
  input wire logic ctrlWrite,
  input wire logic ctrlClockPolaritySelect,
  input wire logic selectIn_n,
  input wire logic sclkOut,
  input wire logic sclkOe,
  input wire logic mosiOe,
  input wire logic selectOut_n,
  input wire logic txBufferEmptyFlag,
  input wire logic rxBufferFullFlag,
  input wire logic modeFaultFlag,
  input wire logic masterSelect,
  input wire logic transferActive
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  fault_drivers_a: assert property (
    $rose(modeFaultFlag) |-> ##[0:1] (!masterSelect && !sclkOe && !mosiOe))
    else $error("fault left a driver on");
  fault_cause_a: assert property (
    $rose(modeFaultFlag) |-> $past(masterSelect) && !$past(selectIn_n, 3))
    else $error("fault without low select in master mode");
  select_lead_a: assert property (
    $fell(selectOut_n) |-> ##1 $stable(sclkOut)[*3] ##1 !$stable(sclkOut))
    else $error("first clock edge not four cycles after select");
  select_trail_a: assert property (
    $rose(selectOut_n) |-> $past(sclkOut, 4) != $past(sclkOut, 5))
    else $error("select release not four cycles after last edge");
  clock_idle_a: assert property (
    $rose(selectOut_n) |-> sclkOut == ctrlClockPolaritySelect)
    else $error("clock idle level differs from polarity");
  edge_gap_a: assert property (
    !$stable(sclkOut) && !selectOut_n |=> $stable(sclkOut)[*3])
    else $error("clock edges closer than half period");
  full_clear_a: assert property (
    $fell(rxBufferFullFlag) |-> $past(dataRead))
    else $error("full flag cleared without data read");
  empty_clear_a: assert property (
    $fell(txBufferEmptyFlag) |-> $past(dataWrite))
    else $error("empty flag cleared without data write");
  fault_clear_a: assert property (
    $fell(modeFaultFlag) |-> $past(ctrlWrite))
    else $error("fault flag cleared without control write");
  full_set_a: assert property (
    $rose(rxBufferFullFlag) && masterSelect |-> $past(transferActive))
    else $error("full flag set outside a transfer");
endmodule

bind spms_core spms_core_chk chk_u (
  .core_clk, .reset_n, .dataWrite, .dataRead, .ctrlWrite, .ctrlClockPolaritySelect,
  .selectIn_n, .sclkOut, .sclkOe, .mosiOe, .selectOut_n, .txBufferEmptyFlag,
  .rxBufferFullFlag, .modeFaultFlag, .masterSelect, .transferActive
);

// file: testbench/spms_slave_model.sv
`timescale 1ns/10ps
module spms_slave_model (
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic       clock_polarity_select,
  input  wire logic       clock_phase_select,
  input  wire logic       lsbFirst,
  input  wire logic [7:0] txByte,
  output logic            miso,
  output logic [7:0]      rxByte
);
  int bitIdx;
  function automatic logic bitAt(int i);
    return lsbFirst ? txByte[i] : txByte[7-i];
  endfunction
  initial begin
    miso = 1'b0;
    rxByte = 8'h00;
    bitIdx = 0;
  end
  always @(negedge sel_n) begin
    bitIdx = 0;
    if (!clock_phase_select) miso = bitAt(0);
  end
  // Released line shows the inverse, so a stale bit never passes
  always @(posedge sel_n) miso = ~miso;
  always @(sclk) begin
    if (!sel_n) begin
      if ((sclk != clock_polarity_select) != clock_phase_select) begin
        rxByte = lsbFirst ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
      end else if (clock_phase_select) begin
        miso = bitAt(bitIdx);
        bitIdx++;
      end else begin
        bitIdx++;
        miso = bitAt(bitIdx % 8);
      end
    end
  end
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic       core_clk, reset_n, dataWrite, dataRead, statusRead, ctrlWrite;
  logic [9:0] ctrl;
  logic       sclkIn, mosiIn, misoIn, selectIn_n, sclkOut, sclkOe, mosiOut, mosiOe;
  logic       misoOut, misoOe, selectOut_n, selectOe, irqRequest, transferActive;
  logic       txBufferEmptyFlag, rxBufferFullFlag, modeFaultFlag, masterSelect;
  logic [7:0] dataWriteValue, serialDataRegister, modelTx, modelRx, b0, b1, s0, s1, got;
  int         fails = 0;
  int         cmp_count = 0;
  int         cyc = 0;

  spms_core dut_u (
    .core_clk, .reset_n, .dataWrite, .dataWriteValue, .dataRead, .statusRead, .ctrlWrite,
    .ctrlEnable(ctrl[9]), .ctrlMasterSelect(ctrl[8]), .ctrlClockPolaritySelect(ctrl[7]),
    .ctrlClockPhaseSelect(ctrl[6]), .ctrlLowBitFirstEnable(ctrl[5]),
    .ctrlRxFaultIrqEnable(ctrl[4]), .ctrlTxEmptyIrqEnable(ctrl[3]),
    .ctrlSelectOutputEnable(ctrl[2]), .ctrlFaultDetectEnable(ctrl[1]), .ctrlBidirMode(ctrl[0]),
    .sclkIn, .mosiIn, .misoIn, .selectIn_n, .sclkOut, .sclkOe, .mosiOut, .mosiOe, .misoOut,
    .misoOe, .selectOut_n, .selectOe, .serialDataRegister, .txBufferEmptyFlag,
    .rxBufferFullFlag, .modeFaultFlag, .masterSelect, .irqRequest, .transferActive);

  spms_slave_model model_u (.sclk(sclkOut), .sel_n(selectOut_n), .mosi(mosiOut),
    .clock_polarity_select(ctrl[7]), .clock_phase_select(ctrl[6]), .lsbFirst(ctrl[5]), .txByte(modelTx), .miso(misoIn),
    .rxByte(modelRx));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic tick(int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask
  task automatic cfg(logic [9:0] c);
    ctrl = c;
    ctrlWrite = 1'b1;
    tick(1);
    ctrlWrite = 1'b0;
  endtask
  task automatic stat();
    statusRead = 1'b1;
    tick(1);
    statusRead = 1'b0;
  endtask
  task automatic wr(logic [7:0] b);
    stat();
    dataWriteValue = b;
    dataWrite = 1'b1;
    tick(1);
    dataWrite = 1'b0;
  endtask
  task automatic rd();
    stat();
    dataRead = 1'b1;
    tick(1);
    dataRead = 1'b0;
  endtask
  // Remote master, phase zero; half period kept at 8 cycles for the synchroniser
  task automatic xfer(logic [7:0] tx, output logic [7:0] rx);
    selectIn_n = 1'b0;
    tick(8);
    for (int i = 7; i >= 0; i--) begin
      mosiIn = tx[i];
      tick(8);
      sclkIn = 1'b1;
      rx[i] = misoOut;
      tick(8);
      sclkIn = 1'b0;
    end
    tick(8);
    chk("miso drive", 8'h01, misoOe);
    selectIn_n = 1'b1;
    tick(8);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    {reset_n, dataWrite, dataRead, statusRead, ctrlWrite, sclkIn, mosiIn} = '0;
    selectIn_n = 1'b1;
    ctrl = '0;
    dataWriteValue = '0;
    modelTx = '0;
    tick(5);
    reset_n = 1'b1;
    chk("reset", 8'h81, {txBufferEmptyFlag, rxBufferFullFlag, modeFaultFlag, masterSelect,
      transferActive, sclkOe, misoOe, selectOut_n});
    cfg(10'h008);
    tick(2);
    chk("empty irq", 8'h01, irqRequest);
    cfg(10'h010);
    tick(2);
    chk("masked irq", 8'h00, irqRequest);
    cfg(10'h300);
    dataWriteValue = 8'h5a;
    dataWrite = 1'b1;
    tick(1);
    dataWrite = 1'b0;
    tick(4);
    chk("unarmed write", 8'h01, {transferActive, txBufferEmptyFlag});
    for (int m = 0; m < 8; m++) begin
      b0 = 8'h1d + 8'(m * 37);
      b1 = ~b0 ^ 8'h42;
      s0 = 8'hb4 ^ 8'(m * 19);
      s1 = ~s0;
      cfg({2'b11, 3'(m), 5'b10110});
      modelTx = s0;
      wr(b0);
      tick(2);
      chk("load start", 8'h06, {txBufferEmptyFlag, transferActive, selectOut_n});
      chk("select oe", 8'h01, selectOe);
      wr(b1);
      chk("queued", 8'h01, {txBufferEmptyFlag, irqRequest, transferActive});
      for (int k = 0; k < 200 && rxBufferFullFlag !== 1'b1; k++) tick(1);
      modelTx = s1;
      chk("far rx 1", b0, modelRx);
      chk("rx data 1", s0, serialDataRegister);
      tick(2);
      chk("full irq", 8'h01, irqRequest);
      tick(100);
      chk("far rx 2", b1, modelRx);
      chk("overrun", s0, serialDataRegister);
      chk("idle", 8'h05, {txBufferEmptyFlag, transferActive, selectOut_n});
      rd();
      chk("full clear", 8'h00, rxBufferFullFlag);
    end
    cfg(10'h200);
    wr(8'h96);
    xfer(8'h3c, got);
    chk("slave out", 8'h96, got);
    chk("slave in", 8'h3c, serialDataRegister);
    cfg(10'h302);
    selectIn_n = 1'b0;
    tick(8);
    chk("fault", 8'h10, {modeFaultFlag, masterSelect, sclkOe, mosiOe, misoOe});
    selectIn_n = 1'b1;
    cfg(10'h200);
    chk("fault held", 8'h01, modeFaultFlag);
    stat();
    cfg(10'h200);
    chk("fault clear", 8'h00, modeFaultFlag);
    complete_run();
  end
endmodule
